/* File: ifd_pkg.sv */
// Constants and types shared by the instruction format decoder files
package ifd_pkg;
	// ***************************************************************
	// Widths and field positions
	// ***************************************************************
	localparam int IFD_WORD_W = 16;
	localparam int IFD_BYTE_W = 8;
	localparam int IFD_DWORD_W = 32;
	localparam int IFD_SEL_W = 4;
	localparam int IFD_REG_N = 16;
	localparam int IFD_OP1_LO = 12;
	localparam int IFD_SELA_LO = 8;
	localparam int IFD_OP2_LO = 4;
	localparam int IFD_SELB_LO = 0;
	localparam int IFD_LIT_LO = 0;
	localparam int IFD_BYTE_SIGN = 7;
	localparam int IFD_MAP_W = 256;

	// ***************************************************************
	// Address arithmetic and addressing modes
	// ***************************************************************
	localparam logic [15:0] IFD_INS_STEP = 16'h0002;
	localparam logic [15:0] IFD_REL_BIAS = 16'h0002;
	localparam logic [15:0] IFD_EVEN_MASK = 16'hFFFE;
	localparam logic [3:0] IFD_MODE_IMM = 4'h0;
	localparam logic [3:0] IFD_MODE_REL = 4'h1;
	localparam logic [3:0] IFD_MODE_ABS = 4'h2;
	localparam logic [3:0] IFD_SEL_STEP = 4'h1;
	localparam logic [15:0] IFD_RST_WORD = 16'h0000;

	// ***************************************************************
	// Default opcode maps, indexed by {first opcode nibble, second opcode nibble}
	// ***************************************************************
	localparam logic [255:0] IFD_TWO_MAP_DEF = 256'h1000_0001;
	localparam logic [255:0] IFD_EMPTY_MAP = 256'h0;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [2:0] {
		IFD_FMT_RR = 3'h0,
		IFD_FMT_RN = 3'h1,
		IFD_FMT_RI = 3'h2,
		IFD_FMT_RL = 3'h3,
		IFD_FMT_TW = 3'h4
	} ifd_fmt_e;

	typedef enum logic [1:0] {
		IFD_ST_FIRST = 2'h1,
		IFD_ST_SECOND = 2'h2
	} ifd_state_e;

	typedef enum logic [1:0] {
		IFD_AM_IMM = 2'h0,
		IFD_AM_REL = 2'h1,
		IFD_AM_ABS = 2'h2,
		IFD_AM_IDX = 2'h3
	} ifd_amode_e;
endpackage

/* File: ifd_fields_if.sv */
// Decoded instruction fields passed from the splitter to the decoder core
`timescale 1ns/1ps
interface ifd_fields_if;
	import ifd_pkg::*;
	logic [3:0] opHi;
	logic [3:0] opLo;
	logic [3:0] firstRegisterField;
	logic [3:0] secondRegisterField;
	logic [7:0] literalField;
	ifd_fmt_e fmt;
	logic twoWord;
	logic ioIn;
	logic ioOut;

	modport split (output opHi, opLo, firstRegisterField,
		secondRegisterField, literalField, fmt, twoWord, ioIn, ioOut);
	modport core (input opHi, opLo, firstRegisterField,
		secondRegisterField, literalField, fmt, twoWord, ioIn, ioOut);
endinterface

/* File: ifd_field_split.sv */
// Splits a first instruction word into fields and classifies its format
`timescale 1ns/1ps
module ifd_field_split #(
	parameter logic [255:0] TWO_MAP = ifd_pkg::IFD_TWO_MAP_DEF,
	parameter logic [255:0] RN_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] RI_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] RL_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] IN_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] OUT_MAP = ifd_pkg::IFD_EMPTY_MAP
) (
	input wire logic [15:0] word,
	ifd_fields_if.split f
);
	import ifd_pkg::*;

	logic [7:0] opKey;

	// ***************************************************************
	// Field extraction
	// ***************************************************************
	// Nibble layout: opcode, first selector, opcode, second selector
	assign f.opHi = word[IFD_OP1_LO +: IFD_SEL_W]; // RQ22
	assign f.firstRegisterField = word[IFD_SELA_LO +: IFD_SEL_W]; // RQ12
	assign f.opLo = word[IFD_OP2_LO +: IFD_SEL_W]; // RQ22
	assign f.secondRegisterField = word[IFD_SELB_LO +: IFD_SEL_W]; // RQ12
	assign f.literalField = word[IFD_LIT_LO +: IFD_BYTE_W]; // RQ17
	assign opKey = {f.opHi, f.opLo};

	// ***************************************************************
	// Format classification
	// ***************************************************************
	// Length comes from the opcode alone; two-word wins over the rest
	always_comb begin
		f.twoWord = TWO_MAP[opKey]; // RQ1
		f.ioIn = IN_MAP[opKey] & ~TWO_MAP[opKey]; // RQ14
		f.ioOut = OUT_MAP[opKey] & ~TWO_MAP[opKey]; // RQ15
		if (TWO_MAP[opKey]) begin
			f.fmt = IFD_FMT_TW;
		end else if (RL_MAP[opKey]) begin
			f.fmt = IFD_FMT_RL;
		end else if (RI_MAP[opKey]) begin
			f.fmt = IFD_FMT_RI;
		end else if (RN_MAP[opKey]) begin
			f.fmt = IFD_FMT_RN; // RQ16
		end else begin
			f.fmt = IFD_FMT_RR;
		end
	end
endmodule

/* File: ifd_decoder.sv */
// Instruction format decoder with general register file
// Function
// RQ1 - Instructions are one or two words, by opcode
// RQ2 - Instructions start only on even byte addresses
// RQ3 - Byte is eight bits, bit 7 most significant
// RQ4 - Word is sixteen bits from two bytes
// RQ5 - Word addressed by even, more significant byte
// RQ6 - Negative values use two's complement form
// RQ7 - Double word is 32 bits, upper word first
// RQ8 - Sixteen 16-bit general registers, four-bit select
// RQ9 - Register byte operations use low byte only
// RQ10 - Signed byte operations take bit 7 as sign
// RQ11 - Register pair: named register upper, next lower
// RQ12 - Two opcode nibbles plus two selector nibbles
// RQ13 - Both registers read; first field is destination
// RQ14 - Input: second gives address, first receives data
// RQ15 - Output: second gives address, first gives data
// RQ16 - Single-register format count gives repeat number
// RQ17 - Immediate: eight-bit literal, register is destination
// RQ18 - Relative target is displacement plus advanced counter
// RQ19 - Relative reach spans -126 to +128 bytes
// RQ20 - Second field selects two-word addressing mode
// RQ21 - Word memory operand address drops its low bit
// RQ22 - Nibbles: opcode, destination, opcode, source
`timescale 1ns/1ps
module ifd_decoder #(
	parameter logic [255:0] TWO_MAP = ifd_pkg::IFD_TWO_MAP_DEF,
	parameter logic [255:0] RN_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] RI_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] RL_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] IN_MAP = ifd_pkg::IFD_EMPTY_MAP,
	parameter logic [255:0] OUT_MAP = ifd_pkg::IFD_EMPTY_MAP
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic insValid,
	input wire logic [15:0] insAddr,
	input wire logic [15:0] insWord,
	input wire logic wrEn,
	input wire logic [3:0] wrSel,
	input wire logic [15:0] wrData,
	input wire logic wrByte,
	input wire logic wrPair,
	input wire logic [15:0] wrDataLo,
	output logic decValid,
	output logic alignFault,
	output ifd_pkg::ifd_fmt_e decFmt,
	output logic decTwoWord,
	output logic [3:0] opHi,
	output logic [3:0] opLo,
	output logic [3:0] destSel,
	output logic [3:0] srcSel,
	output logic [3:0] repCount,
	output logic [15:0] operandA,
	output logic [15:0] operandB,
	output logic [15:0] byteA,
	output logic [31:0] pairA,
	output logic [31:0] pairB,
	output logic [15:0] literalValue,
	output logic [15:0] relTarget,
	output ifd_pkg::ifd_amode_e addrMode,
	output logic [15:0] immData,
	output logic [15:0] eaByte,
	output logic [15:0] eaWord,
	output logic [15:0] eaLowWord,
	output logic ioIn,
	output logic ioOut,
	output logic [15:0] ioAddr,
	output logic [15:0] ioData
);
	import ifd_pkg::*;

	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		ifd_state_e st;
		logic [IFD_REG_N-1:0][IFD_WORD_W-1:0] regs;
		logic [15:0] firstWord;
		logic [15:0] firstAddr;
		logic decValid;
		logic alignFault;
		ifd_fmt_e fmt;
		logic twoWord;
		logic [3:0] opHi;
		logic [3:0] opLo;
		logic [3:0] destSel;
		logic [3:0] srcSel;
		logic [3:0] repCount;
		logic [15:0] operandA;
		logic [15:0] operandB;
		logic [15:0] byteA;
		logic [31:0] pairA;
		logic [31:0] pairB;
		logic [15:0] literalValue;
		logic [15:0] relTarget;
		ifd_amode_e addrMode;
		logic [15:0] immData;
		logic [15:0] eaByte;
		logic [15:0] eaWord;
		logic [15:0] eaLowWord;
		logic ioIn;
		logic ioOut;
		logic [15:0] ioAddr;
		logic [15:0] ioData;
	} ifd_state_s;

	ifd_state_s s_q;
	ifd_state_s s_d;
	logic [15:0] splitWord;

	ifd_fields_if fld ();

	// ***************************************************************
	// Helper functions
	// ***************************************************************
	// Sign-extends a byte into a word using bit 7 as sign
	function automatic logic [15:0] sext8(input logic [7:0] b);
		sext8 = {{IFD_BYTE_W{b[IFD_BYTE_SIGN]}}, b}; // RQ3 RQ6 RQ10
	endfunction

	// Reads a register pair, named register as the upper half
	function automatic logic [31:0] pairOf(
		input logic [IFD_REG_N-1:0][IFD_WORD_W-1:0] r,
		input logic [3:0] sel);
		logic [3:0] nxt;
		nxt = sel + IFD_SEL_STEP; // Selector wraps past 15
		pairOf = {r[sel], r[nxt]}; // RQ7 RQ11
	endfunction

	// ***************************************************************
	// Field splitter
	// ***************************************************************
	// The held first word is decoded while the second word arrives
	assign splitWord = (s_q.st == IFD_ST_FIRST) ? insWord : s_q.firstWord;

	ifd_field_split #(
		.TWO_MAP(TWO_MAP),
		.RN_MAP(RN_MAP),
		.RI_MAP(RI_MAP),
		.RL_MAP(RL_MAP),
		.IN_MAP(IN_MAP),
		.OUT_MAP(OUT_MAP)
	) uSplit (
		.word(splitWord),
		.f(fld.split)
	);

	// ***************************************************************
	// Next-state logic
	// ***************************************************************
	// Sequences one- and two-word instructions and fills the outputs
	always_comb begin
		logic fin;
		logic [15:0] a1;
		logic [15:0] w2;
		logic [15:0] pc;
		logic [15:0] ea;
		logic [15:0] rA;
		logic [15:0] rB;
		logic [3:0] nx;
		fin = 1'b0;
		a1 = s_q.firstAddr;
		w2 = insWord;
		pc = IFD_RST_WORD;
		ea = IFD_RST_WORD;
		rA = s_q.regs[fld.firstRegisterField]; // RQ8
		rB = s_q.regs[fld.secondRegisterField]; // RQ8
		nx = wrSel + IFD_SEL_STEP;
		s_d = s_q;
		s_d.decValid = 1'b0;
		s_d.alignFault = 1'b0;

		// Register write port from the execution stage
		if (wrEn) begin
			if (wrPair) begin
				s_d.regs[wrSel] = wrData; // RQ11
				s_d.regs[nx] = wrDataLo; // RQ11
			end else if (wrByte) begin
				s_d.regs[wrSel][IFD_BYTE_W-1:0] =
					wrData[IFD_BYTE_W-1:0]; // RQ9
			end else begin
				s_d.regs[wrSel] = wrData; // RQ4
			end
		end

		unique case (s_q.st)
			IFD_ST_FIRST: begin
				if (insValid) begin
					if (insAddr[0]) begin
						s_d.alignFault = 1'b1; // RQ2
					end else if (fld.twoWord) begin
						s_d.firstWord = insWord; // RQ1
						s_d.firstAddr = insAddr;
						s_d.st = IFD_ST_SECOND;
					end else begin
						a1 = insAddr;
						fin = 1'b1; // RQ1
					end
				end
			end
			IFD_ST_SECOND: begin
				if (insValid) begin
					fin = 1'b1;
					s_d.st = IFD_ST_FIRST;
				end
			end
		endcase

		// Fields and operands of the completed instruction
		if (fin) begin
			pc = a1 + IFD_INS_STEP; // Counter is one word (two bytes) past the first word
			s_d.decValid = 1'b1;
			s_d.fmt = fld.fmt;
			s_d.twoWord = fld.twoWord;
			s_d.opHi = fld.opHi;
			s_d.opLo = fld.opLo;
			s_d.destSel = fld.firstRegisterField; // RQ13 RQ17
			s_d.srcSel = fld.secondRegisterField;
			s_d.repCount = fld.secondRegisterField; // RQ16
			s_d.operandA = rA; // RQ13
			s_d.operandB = rB; // RQ13
			s_d.byteA = sext8(rA[IFD_BYTE_W-1:0]); // RQ9 RQ10
			s_d.pairA = pairOf(s_q.regs, fld.firstRegisterField);
			s_d.pairB = pairOf(s_q.regs, fld.secondRegisterField);
			s_d.literalValue = sext8(fld.literalField); // RQ17
			// Displacement -128..127 plus bias gives -126..+128 bytes
			s_d.relTarget = (pc + sext8(fld.literalField) + IFD_REL_BIAS)
				& IFD_EVEN_MASK; // RQ18 RQ19 RQ2
			s_d.ioIn = fld.ioIn;
			s_d.ioOut = fld.ioOut;
			s_d.ioAddr = rB; // RQ14 RQ15
			s_d.ioData = rA; // RQ15
			s_d.immData = IFD_RST_WORD;
			s_d.addrMode = IFD_AM_IMM;
			s_d.eaByte = IFD_RST_WORD;
			if (fld.twoWord) begin
				// Second word is big-end: even byte in the upper half
				s_d.immData = w2; // RQ5
				if (fld.secondRegisterField == IFD_MODE_IMM) begin
					s_d.addrMode = IFD_AM_IMM; // RQ20
					ea = pc;
				end else if (fld.secondRegisterField == IFD_MODE_REL) begin
					s_d.addrMode = IFD_AM_REL; // RQ20
					ea = pc + w2; // RQ6
				end else if (fld.secondRegisterField == IFD_MODE_ABS) begin
					s_d.addrMode = IFD_AM_ABS; // RQ20
					ea = w2;
				end else begin
					s_d.addrMode = IFD_AM_IDX; // RQ20
					ea = w2 + rB;
				end
				s_d.eaByte = ea;
			end
			s_d.eaWord = ea & IFD_EVEN_MASK; // RQ21 RQ5
			// Less significant word of a double sits two bytes on
			s_d.eaLowWord = (ea & IFD_EVEN_MASK) + IFD_INS_STEP; // RQ7
		end
	end

	// ***************************************************************
	// State register
	// ***************************************************************
	// Holds all decoder state; registers clear at reset, the state field loads IFD_ST_FIRST
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= IFD_ST_FIRST;
		end else begin
			s_q <= s_d;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	// Every output comes straight from the state register
	assign decValid = s_q.decValid;
	assign alignFault = s_q.alignFault;
	assign decFmt = s_q.fmt;
	assign decTwoWord = s_q.twoWord;
	assign opHi = s_q.opHi;
	assign opLo = s_q.opLo;
	assign destSel = s_q.destSel;
	assign srcSel = s_q.srcSel;
	assign repCount = s_q.repCount;
	assign operandA = s_q.operandA;
	assign operandB = s_q.operandB;
	assign byteA = s_q.byteA;
	assign pairA = s_q.pairA;
	assign pairB = s_q.pairB;
	assign literalValue = s_q.literalValue;
	assign relTarget = s_q.relTarget;
	assign addrMode = s_q.addrMode;
	assign immData = s_q.immData;
	assign eaByte = s_q.eaByte;
	assign eaWord = s_q.eaWord;
	assign eaLowWord = s_q.eaLowWord;
	assign ioIn = s_q.ioIn;
	assign ioOut = s_q.ioOut;
	assign ioAddr = s_q.ioAddr;
	assign ioData = s_q.ioData;
endmodule

/* File: ifd_decoder_sva.sv */
// Port-level assertion checker for the instruction format decoder
`timescale 1ns/1ps
module ifd_decoder_sva #(
	parameter logic [255:0] TWO_MAP = ifd_pkg::IFD_TWO_MAP_DEF
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic insValid,
	input wire logic [15:0] insAddr,
	input wire logic [15:0] insWord,
	input wire logic decValid,
	input wire logic alignFault,
	input wire logic decTwoWord,
	input wire logic [3:0] opHi,
	input wire logic [3:0] destSel,
	input wire logic [3:0] srcSel,
	input wire logic [3:0] repCount,
	input wire logic [15:0] literalValue,
	input ifd_pkg::ifd_amode_e addrMode,
	input wire logic [15:0] eaByte,
	input wire logic [15:0] eaWord,
	input wire logic [15:0] eaLowWord
);
	import ifd_pkg::*;
	// ****************
	// Tracking of first and second words
	// ****************
	logic waitSecond_q;
	logic firstTake;
	logic isTwo;
	// A word taken while idle is a first word
	assign firstTake = insValid && !waitSecond_q;
	assign isTwo = TWO_MAP[{insWord[15:12], insWord[7:4]}];
	// Set after an aligned two-word opener, cleared by its second word
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) waitSecond_q <= 1'b0;
		else if (insValid) waitSecond_q <= firstTake && !insAddr[0] && isTwo;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// ****************
	// Assertions
	// ****************
	chk_align_fault: assert property (
		firstTake && insAddr[0] |=> alignFault && !decValid)
		else $error("odd first word not refused");
	chk_one_word: assert property (
		firstTake && !insAddr[0] && !isTwo |=> decValid && !decTwoWord)
		else $error("one-word decode missing");
	chk_two_wait: assert property (
		firstTake && !insAddr[0] && isTwo |=> !decValid && !alignFault)
		else $error("two-word opener finished early");
	chk_two_word: assert property (
		firstTake && !insAddr[0] && isTwo ##1 insValid |=> decValid && decTwoWord)
		else $error("two-word decode missing");
	chk_field_pos: assert property (
		firstTake && !insAddr[0] && !isTwo |=> {opHi, destSel, srcSel} ==
		{$past(insWord[15:8]), $past(insWord[3:0])} && repCount == srcSel)
		else $error("field positions wrong");
	chk_mode_sel: assert property (
		decValid && decTwoWord |-> addrMode == (srcSel > 4'h2 ? 2'h3 : srcSel[1:0]))
		else $error("addressing mode wrong");
	chk_ea_even: assert property (
		decValid && decTwoWord |-> eaWord == (eaByte & IFD_EVEN_MASK) &&
		eaLowWord == eaWord + IFD_INS_STEP)
		else $error("word address not even");
	chk_hold_out: assert property (
		!decValid |-> $stable(destSel) && $stable(literalValue) && $stable(eaByte))
		else $error("output changed without decode");
endmodule

bind ifd_decoder ifd_decoder_sva #(.TWO_MAP(TWO_MAP)) uChk (
	.mclk(mclk), .rstn(rstn), .insValid(insValid), .insAddr(insAddr),
	.insWord(insWord), .decValid(decValid), .alignFault(alignFault),
	.decTwoWord(decTwoWord), .opHi(opHi), .destSel(destSel), .srcSel(srcSel),
	.repCount(repCount), .literalValue(literalValue), .addrMode(addrMode),
	.eaByte(eaByte), .eaWord(eaWord), .eaLowWord(eaLowWord)
);

/* File: tb.sv */
// Self-checking testbench for the instruction format decoder
`timescale 1ns/1ps
module tb;
	import ifd_pkg::*;
	// ****************
	// Maps, signals and reference state
	// ****************
	localparam logic [255:0] TW_M = IFD_TWO_MAP_DEF;
	localparam logic [255:0] RN_M = 256'h1 << 8'h21;
	localparam logic [255:0] RI_M = 256'h1 << 8'h3F;
	localparam logic [255:0] RL_M = (256'h1 << 8'h48) | (256'h1 << 8'h47);
	localparam logic [255:0] IN_M = 256'h1 << 8'h51;
	localparam logic [255:0] OUT_M = 256'h1 << 8'h61;
	typedef struct {
		logic flt;
		logic [15:0] a, w1, w2, ra, ra1, rb, rb1;
	} ifd_exp_s;
	logic mclk = 1'b0;
	logic rstn, insValid, wrEn, wrByte, wrPair, decValid, alignFault;
	logic decTwoWord, ioIn, ioOut;
	logic [3:0] wrSel, opHi, opLo, destSel, srcSel, repCount;
	logic [15:0] insAddr, insWord, wrData, wrDataLo, operandA, operandB, byteA;
	logic [15:0] literalValue, relTarget, immData, eaByte, eaWord, eaLowWord;
	logic [15:0] ioAddr, ioData, a, m[16];
	logic [31:0] pairA, pairB, r;
	ifd_fmt_e decFmt;
	ifd_amode_e addrMode;
	ifd_exp_s q[$];
	logic [7:0] ops[8] = '{8'h00, 8'h1C, 8'h21, 8'h3F, 8'h48, 8'h47,
		8'h51, 8'h61};
	int errCount, nTests, seed;
	// Free-running 200 MHz clock
	always #2.5 mclk = ~mclk;
	ifd_decoder #(.RN_MAP(RN_M), .RI_MAP(RI_M), .RL_MAP(RL_M),
		.IN_MAP(IN_M), .OUT_MAP(OUT_M)) DUT (
		.mclk(mclk), .rstn(rstn), .insValid(insValid), .insAddr(insAddr),
		.insWord(insWord), .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData),
		.wrByte(wrByte), .wrPair(wrPair), .wrDataLo(wrDataLo),
		.decValid(decValid), .alignFault(alignFault), .decFmt(decFmt),
		.decTwoWord(decTwoWord), .opHi(opHi), .opLo(opLo),
		.destSel(destSel), .srcSel(srcSel), .repCount(repCount),
		.operandA(operandA), .operandB(operandB), .byteA(byteA),
		.pairA(pairA), .pairB(pairB), .literalValue(literalValue),
		.relTarget(relTarget), .addrMode(addrMode), .immData(immData),
		.eaByte(eaByte), .eaWord(eaWord), .eaLowWord(eaLowWord),
		.ioIn(ioIn), .ioOut(ioOut), .ioAddr(ioAddr), .ioData(ioData));
	// ****************
	// Reference functions and tasks
	// ****************
	function automatic logic [15:0] sx(input logic [15:0] w);
		return {{8{w[7]}}, w[7:0]};
	endfunction
	function automatic ifd_fmt_e fmtOf(input logic [7:0] op);
		if (TW_M[op]) return IFD_FMT_TW;
		if (RL_M[op]) return IFD_FMT_RL;
		if (RI_M[op]) return IFD_FMT_RI;
		if (RN_M[op]) return IFD_FMT_RN;
		return IFD_FMT_RR;
	endfunction
	task chk(input logic [31:0] g, e, input string s);
		nTests++;
		if (g !== e) begin
			errCount++;
			$display("Error at %0t: %s got %h exp %h", $time, s, g, e);
		end
	endtask
	task chkFlag(input logic g, e, input string s);
		chk({31'h0, g}, {31'h0, e}, s);
	endtask
	// Register write, mirrored in the reference file
	task wr(input logic [3:0] s, input logic [15:0] d, lo, input logic b, p);
		@(posedge mclk);
		insValid <= 1'b0;
		wrEn <= 1'b1;
		wrSel <= s;
		wrData <= d;
		wrDataLo <= lo;
		wrByte <= b;
		wrPair <= p;
		if (p) begin
			m[s] = d;
			m[s + 4'h1] = lo;
		end else if (b) m[s][7:0] = d[7:0];
		else m[s] = d;
	endtask
	task put(input logic [15:0] ad, w);
		@(posedge mclk);
		wrEn <= 1'b0;
		insValid <= 1'b1;
		insAddr <= ad;
		insWord <= w;
	endtask
	task idle;
		@(posedge mclk);
		wrEn <= 1'b0;
		insValid <= 1'b0;
	endtask
	// Second word goes out at an odd address, which must be ignored
	task ins(input logic [15:0] ad, w1, w2);
		ifd_exp_s e;
		e = '{ad[0], ad, w1, w2, m[w1[11:8]], m[w1[11:8] + 4'h1],
			m[w1[3:0]], m[w1[3:0] + 4'h1]};
		put(ad, w1);
		if (!ad[0] && TW_M[{w1[15:12], w1[7:4]}]) put(ad + 16'h0003, w2);
		q.push_back(e);
	endtask
	task check(input ifd_exp_s e);
		logic [7:0] op;
		logic [3:0] s;
		logic two;
		logic [15:0] ea, ew, rt;
		op = {e.w1[15:12], e.w1[7:4]};
		s = e.w1[3:0];
		two = TW_M[op];
		ea = s == 4'h0 ? e.a + 16'h0002 : s == 4'h1 ? e.a + 16'h0002 + e.w2 :
			s == 4'h2 ? e.w2 : e.w2 + e.rb;
		ew = ea & IFD_EVEN_MASK;
		// Counter is two bytes on, displacement gets two more
		rt = (e.a + sx(e.w1) + 16'h0004) & IFD_EVEN_MASK;
		chkFlag(alignFault, e.flt, "fault");
		chkFlag(decValid, !e.flt, "valid");
		if (e.flt) return;
		chkFlag(decTwoWord, two, "length");
		chk(decFmt, fmtOf(op), "format");
		chk({opHi, destSel, opLo, srcSel}, e.w1, "fields");
		chk(repCount, s, "count");
		chk({operandA, operandB}, {e.ra, e.rb}, "operands");
		chk(byteA, sx(e.ra), "byte");
		chk(pairA, {e.ra, e.ra1}, "pair a");
		chk(pairB, {e.rb, e.rb1}, "pair b");
		chk(literalValue, sx(e.w1), "literal");
		chk({ioAddr, ioData}, {e.rb, e.ra}, "io regs");
		chk({ioIn, ioOut}, {IN_M[op], OUT_M[op]} & {2{!two}}, "io");
		chk(addrMode, two ? (s > 4'h2 ? 2'h3 : s[1:0]) : 2'h0, "mode");
		if (fmtOf(op) == IFD_FMT_RL)
			chk(relTarget, rt, "rel");
		if (two) chk({immData, eaByte}, {e.w2, ea}, "ea");
		else chk({immData, eaByte}, 32'h0, "no ea");
		if (two) chk({eaWord, eaLowWord}, {ew, ew + 16'h0002}, "ea word");
	endtask
	task resetDut;
		@(posedge mclk);
		rstn <= 1'b0;
		insValid <= 1'b0;
		wrEn <= 1'b0;
		repeat (20) @(posedge mclk);
		chk({decValid, alignFault, decFmt, destSel, operandA}, 0, "reset");
		rstn <= 1'b1;
		foreach (m[i]) m[i] = 16'h0;
		q.delete();
		$display("Test reset done");
	endtask
	task finishTest;
		if (q.size() != 0) chk(q.size(), 0, "missing results");
		$display("Checks %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Compare each decode or refusal with the oldest expectation
	always @(negedge mclk) begin
		if (rstn && (decValid === 1'b1 || alignFault === 1'b1)) begin
			if (q.size() == 0) chk(1, 0, "unexpected result");
			else check(q.pop_front());
		end
	end
	// Watchdog against a hung run
	initial begin
		#100000;
		chk(1, 0, "watchdog expired");
		finishTest();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		seed = 78790;
		{rstn, insValid, wrEn, wrByte, wrPair, wrSel} = 9'h0;
		{insAddr, insWord, wrData, wrDataLo} = 64'h0;
		resetDut();
		// Worked example in every addressing mode, odd index sum
		wr(4'h4, 16'h01AC, 16'h0000, 1'b0, 1'b0);
		wr(4'h3, 16'h0001, 16'h0000, 1'b0, 1'b0);
		for (int i = 0; i < 16; i++) ins(16'h10AC, {12'h050, 4'(i)}, 16'h01B0);
		// Relative reach ends, refusal, pair wrap and byte write
		ins(16'h0010, 16'h4080, 16'h0000);
		ins(16'h0010, 16'h407F, 16'h0000);
		ins(16'h0101, 16'h7F20, 16'h0000);
		ins(16'h0102, 16'h7F20, 16'h0000);
		wr(4'hF, 16'h8001, 16'h7FFE, 1'b1, 1'b1);
		wr(4'h2, 16'hFF80, 16'h0000, 1'b1, 1'b0);
		ins(16'h0104, 16'h7F22, 16'h0000);
		idle();
		$display("Test corner cases done");
		repeat (400) begin
			r = $random(seed);
			if (r[1:0] == 2'h0)
				wr(r[7:4], 16'($random(seed)), 16'($random(seed)), r[8], r[9]);
			else begin
				a = 16'($random(seed));
				if (r[12]) {a[15:12], a[7:4]} = ops[r[4:2]];
				ins({r[31:17], r[11:10] == 2'h0}, a, 16'($random(seed)));
			end
			if (r[13]) idle();
		end
		idle();
		$display("Test random done");
		resetDut();
		ins(16'h0000, 16'h7F20, 16'h0000);
		repeat (3) idle();
		finishTest();
	end
endmodule
